// ---- verilog/lbl_pkg.sv ----
/*
  lbl_pkg: constants, types and helper functions for the LAN/WAN
  learning bridge. Assumes a 25 MHz core clock.
*/
package lbl_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS         = 1000000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // address ageing
  localparam int AGE_TIME_MIN = 8;
  localparam int AGE_TICK_MS  = 1000;
  localparam int AGE_LIMIT    = AGE_TIME_MIN * 60 * 1000 / AGE_TICK_MS;
  localparam int AGE_W        = 9;
  localparam logic [AGE_W-1:0] AGE_LAST = AGE_W'(AGE_LIMIT - 1);
  localparam logic [9:0]  SEC_LAST = 10'(AGE_TICK_MS - 1);

  // status lamp timing, in ms
  localparam logic [11:0] PULSE_ON_MS  = 12'd250;
  localparam logic [11:0] PULSE_OFF_MS = 12'd250;
  localparam logic [11:0] GAP_MS       = 12'd2000;
  localparam logic [11:0] SAT_MS       = 12'd100;
  localparam logic [3:0]  SHOW_TIMES   = 4'd8;
  localparam int          NUM_CODES    = 11;

  // status codes (pulse counts)
  localparam logic [3:0] CODE_OK = 4'h1;

  // wan framing
  localparam logic [7:0]  HDLC_FLAG  = 8'h7e;
  localparam logic [7:0]  HDLC_ABORT = 8'hff;
  localparam logic [15:0] FCS_INIT   = 16'hffff;
  localparam logic [15:0] FCS_POLY   = 16'h8408;
  localparam logic [10:0] HDR_LAST   = 11'h005;
  localparam logic [10:0] MAC_LAST   = 11'h005;
  localparam logic [10:0] SRC_FIRST  = 11'h006;
  localparam logic [10:0] SRC_LAST   = 11'h00b;
  localparam logic [2:0]  STUFF_ONES = 3'h5;

  typedef enum logic [3:0] {
    F_IDLE = 4'h0, F_DST  = 4'h1, F_LOOK = 4'h2, F_HDR  = 4'h3,
    F_SDST = 4'h4, F_BODY = 4'h5, F_FCS  = 4'h6, F_DROP = 4'h7,
    F_LEARN = 4'h8, F_AGE = 4'h9
  } lbl_fstate_t;

  typedef enum logic [1:0] {
    L_PICK = 2'h0, L_ON = 2'h1, L_OFF = 2'h2, L_GAP = 2'h3
  } lbl_lstate_t;

  // ppp address, control, bridged-lan protocol, bcp flags, 802.3 mac type
  function automatic logic [7:0] lbl_hdr_byte(input logic [2:0] i);
    case (i)
      3'h0:    lbl_hdr_byte = 8'hff;
      3'h1:    lbl_hdr_byte = 8'h03;
      3'h2:    lbl_hdr_byte = 8'h00;
      3'h3:    lbl_hdr_byte = 8'h31;
      3'h4:    lbl_hdr_byte = 8'h00;
      default: lbl_hdr_byte = 8'h01;
    endcase
  endfunction : lbl_hdr_byte

  // reflected crc-16 over one byte, lsb first
  function automatic logic [15:0] lbl_fcs16(input logic [15:0] c,
                                            input logic [7:0]  b);
    logic [15:0] r;
    r = c;
    for (int k = 0; k < 8; k++) begin
      r = (r[0] ^ b[k]) ? ((r >> 1) ^ FCS_POLY) : (r >> 1);
    end
    lbl_fcs16 = r;
  endfunction : lbl_fcs16

endpackage : lbl_pkg

// ---- verilog/lbl_mac_ram.sv ----
/*
  lbl_mac_ram: single-port address table memory with registered read.
  Assumes one access per cycle; a write does not update read data.
*/
`timescale 1ns/1ns
module lbl_mac_ram #(
  parameter int W     = 58,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [W-1:0]  wdata_in,
  output logic      [W-1:0]  rdata_out
);
  logic [W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH != (1 << AW)) $error("lbl_mac_ram: DEPTH must be 2**AW");
  end

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule : lbl_mac_ram

// ---- verilog/lbl_bridge.sv ----
/*
  lbl_bridge: learning mac bridge, lan byte stream in, sync ppp/bcp
  serial out, status and link lamps. Assumes lan and wan-receive error
  pulses come from logic on core_clk_in; wan clock, cts, cd and link
  are asynchronous pins.
*/
`timescale 1ns/1ns
module lbl_bridge
  import lbl_pkg::*;
#(
  parameter int ENTRIES   = 16,
  parameter int MS_CYCLES = CYC_PER_MS
) (
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] lan_rx_data_in,
  input  wire logic       lan_rx_valid_in,
  input  wire logic       lan_rx_sof_in,
  input  wire logic       lan_rx_eof_in,
  output logic            lan_rx_ready_out,
  input  wire logic       lan_rx_oversize_in,
  input  wire logic       lan_rx_misalign_in,
  input  wire logic       lan_rx_crc_err_in,
  input  wire logic       lan_link_ok_in,
  input  wire logic       wan_clk_in,
  input  wire logic       wan_cts_in,
  input  wire logic       wan_cd_in,
  output logic            wan_txd_out,
  input  wire logic       wan_rx_oversize_in,
  input  wire logic       wan_rx_misalign_in,
  input  wire logic       wan_rx_abort_in,
  input  wire logic       wan_rx_crc_err_in,
  output logic            status_led_out,
  output logic            link_led_out
);
  localparam int AW = $clog2(ENTRIES);
  localparam int EW = 1 + AGE_W + 48;

  initial begin
    if (ENTRIES < 2 || ENTRIES != (1 << AW)) $error("ENTRIES: power of two");
    if (MS_CYCLES < 2 || MS_CYCLES > 65535) $error("MS_CYCLES out of range");
  end

  typedef struct packed {
    logic wclk_s1, wclk_s2, wclk_s3;
    logic cts_s1, cts_s2, cd_s1, cd_s2, lnk_s1, lnk_s2;
    lbl_fstate_t fst;
    logic [10:0] idx;
    logic [47:0] dst, src;
    logic [AW-1:0] scan_i, free_i;
    logic rd_ph, free_ok, hit;
    logic [AW:0] n_used;
    logic [15:0] ms_cnt;
    logic [9:0] sec_ms;
    logic age_pend;
    logic [11:0] sat_ms;
    logic [7:0] sh;
    logic [3:0] bits;
    logic [2:0] ones;
    logic dat, txd;
    logic [15:0] fcs;
    lbl_lstate_t lst;
    logic [3:0] code, left;
    logic [11:0] lms;
    logic [NUM_CODES:1] latch;
    logic [NUM_CODES:1][3:0] shown;
    logic sled, lled;
    logic [1:0] warm;
  } lbl_bridge_st_t;

  lbl_bridge_st_t s_q, s_d;
  logic rst_s1_q, rst_s2_q;
  logic ram_we;
  logic [AW-1:0] ram_addr;
  logic [EW-1:0] ram_wdata, ram_rdata;

  lbl_mac_ram #(.W(EW), .DEPTH(ENTRIES), .AW(AW)) u_ram (
    .clk_in    (core_clk_in),
    .we_in     (ram_we),
    .addr_in   (ram_addr),
    .wdata_in  (ram_wdata),
    .rdata_out (ram_rdata)
  );

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  always_comb begin
    logic wtick, mtick, link_up, byte_dat, stuff, is_hit, is_free, last;
    logic [7:0] cur;
    logic [47:0] key;
    logic [NUM_CODES:1] ev, act;
    logic [AGE_W-1:0] age;
    s_d = s_q;
    wtick = 1'b0; mtick = 1'b0; link_up = 1'b0; byte_dat = 1'b0;
    stuff = 1'b0; is_hit = 1'b0; is_free = 1'b0; last = 1'b0;
    cur = HDLC_FLAG; key = '0; ev = '0; act = '0; age = '0;
    lan_rx_ready_out = 1'b0;
    ram_we = 1'b0;
    ram_addr = s_q.scan_i;
    ram_wdata = '0;

    // pin synchronisers
    s_d.wclk_s1 = wan_clk_in;
    s_d.wclk_s2 = s_q.wclk_s1;
    s_d.wclk_s3 = s_q.wclk_s2;
    s_d.cts_s1 = wan_cts_in;
    s_d.cts_s2 = s_q.cts_s1;
    s_d.cd_s1 = wan_cd_in;
    s_d.cd_s2 = s_q.cd_s1;
    s_d.lnk_s1 = lan_link_ok_in;
    s_d.lnk_s2 = s_q.lnk_s1;
    // shift on the falling edge, driver samples on the rising one
    wtick = s_q.wclk_s3 & ~s_q.wclk_s2;
    link_up = s_q.cts_s2 & s_q.cd_s2;
    // cts/cd synchronisers hold reset zeros for two cycles
    s_d.warm = s_q.warm[1] ? s_q.warm : s_q.warm + 2'h1;
    s_d.lled = s_q.lnk_s2;

    // millisecond and age ticks
    mtick = (s_q.ms_cnt == 16'(MS_CYCLES - 1));
    s_d.ms_cnt = mtick ? 16'h0 : s_q.ms_cnt + 16'h1;
    if (mtick) begin
      s_d.sec_ms = (s_q.sec_ms == SEC_LAST) ? 10'h0 : s_q.sec_ms + 10'h1;
    end
    if (mtick && s_q.sec_ms == SEC_LAST) s_d.age_pend = 1'b1;

    // wan bit engine with zero insertion and byte fetch
    if (wtick) begin
      stuff = s_q.dat && (s_q.ones == STUFF_ONES);
      if (stuff) begin
        s_d.txd = 1'b0;
        s_d.ones = 3'h0;
      end else begin
        if (s_q.bits == 4'h0) begin
          case (s_q.fst)
            F_HDR: begin
              cur = lbl_hdr_byte(s_q.idx[2:0]);
              byte_dat = 1'b1;
              s_d.fcs = lbl_fcs16(s_q.fcs, cur);
              s_d.idx = (s_q.idx == HDR_LAST) ? 11'h0 : s_q.idx + 11'h1;
              if (s_q.idx == HDR_LAST) s_d.fst = F_SDST;
            end
            F_SDST: begin
              cur = s_q.dst[47:40];
              byte_dat = 1'b1;
              s_d.fcs = lbl_fcs16(s_q.fcs, cur);
              s_d.dst = {s_q.dst[39:0], s_q.dst[47:40]};
              s_d.idx = s_q.idx + 11'h1;
              if (s_q.idx == MAC_LAST) s_d.fst = F_BODY;
            end
            F_BODY: begin
              if (lan_rx_valid_in) begin
                cur = lan_rx_data_in;
                byte_dat = 1'b1;
                lan_rx_ready_out = 1'b1;
                s_d.fcs = lbl_fcs16(s_q.fcs, cur);
                s_d.idx = s_q.idx + 11'h1;
                if (s_q.idx >= SRC_FIRST && s_q.idx <= SRC_LAST) begin
                  s_d.src = {s_q.src[39:0], lan_rx_data_in};
                end
                if (lan_rx_eof_in) begin
                  s_d.fst = F_FCS;
                  s_d.idx = 11'h0;
                end
              end else begin
                cur = HDLC_ABORT;
                s_d.fst = F_DROP;
              end
            end
            F_FCS: begin
              cur = s_q.idx[0] ? ~s_q.fcs[15:8] : ~s_q.fcs[7:0];
              byte_dat = 1'b1;
              s_d.idx = s_q.idx + 11'h1;
              if (s_q.idx[0]) begin
                s_d.fst = F_LEARN;
                s_d.scan_i = '0;
                s_d.free_ok = 1'b0;
                s_d.hit = 1'b0;
              end
            end
            default: cur = HDLC_FLAG;
          endcase
        end else begin
          cur = s_q.sh;
          byte_dat = s_q.dat;
        end
        s_d.txd = cur[0];
        s_d.sh = {1'b0, cur[7:1]};
        s_d.bits = (s_q.bits == 4'h0) ? 4'h7 : s_q.bits - 4'h1;
        s_d.dat = byte_dat;
        s_d.ones = (byte_dat && cur[0]) ? s_q.ones + 3'h1 : 3'h0;
      end
    end

    // frame handling and table scans
    key = (s_q.fst == F_LOOK) ? s_q.dst : s_q.src;
    is_hit = ram_rdata[EW-1] && (ram_rdata[47:0] == key);
    is_free = !ram_rdata[EW-1];
    last = (s_q.scan_i == AW'(ENTRIES - 1));
    age = ram_rdata[48 +: AGE_W];
    case (s_q.fst)
      F_IDLE: begin
        if (s_q.age_pend) begin
          s_d.fst = F_AGE;
          s_d.scan_i = '0;
          s_d.rd_ph = 1'b0;
          s_d.age_pend = 1'b0 | (mtick && s_q.sec_ms == SEC_LAST);
        end else if (lan_rx_valid_in) begin
          lan_rx_ready_out = 1'b1;
          s_d.idx = 11'h1;
          s_d.dst = {40'h0, lan_rx_data_in};
          if (lan_rx_sof_in) s_d.fst = F_DST;
        end
      end
      F_DST: begin
        if (lan_rx_valid_in) begin
          lan_rx_ready_out = 1'b1;
          s_d.dst = {s_q.dst[39:0], lan_rx_data_in};
          s_d.idx = s_q.idx + 11'h1;
          s_d.scan_i = '0;
          s_d.rd_ph = 1'b0;
          s_d.fcs = FCS_INIT;
          if (lan_rx_eof_in) begin
            s_d.fst = F_IDLE;
          end else if (s_q.idx == MAC_LAST) begin
            s_d.idx = 11'h0;
            if (!link_up) begin
              s_d.fst = F_DROP;
              s_d.idx = SRC_FIRST;
            end
            else if (s_q.dst[32]) s_d.fst = F_HDR;
            else s_d.fst = F_LOOK;
          end
        end
      end
      F_LOOK: begin
        s_d.rd_ph = ~s_q.rd_ph;
        if (s_q.rd_ph) begin
          s_d.scan_i = s_q.scan_i + AW'(1);
          if (is_hit) begin
            s_d.fst = F_DROP;
            s_d.idx = SRC_FIRST;
          end else if (last) begin
            s_d.fst = F_HDR;
            s_d.idx = 11'h0;
          end
        end
      end
      F_DROP: begin
        if (lan_rx_valid_in) begin
          lan_rx_ready_out = 1'b1;
          s_d.idx = s_q.idx + 11'h1;
          if (s_q.idx >= SRC_FIRST && s_q.idx <= SRC_LAST) begin
            s_d.src = {s_q.src[39:0], lan_rx_data_in};
          end
          if (lan_rx_eof_in) begin
            s_d.fst = F_LEARN;
            s_d.scan_i = '0;
            s_d.rd_ph = 1'b0;
            s_d.free_ok = 1'b0;
            s_d.hit = 1'b0;
          end
        end
      end
      F_LEARN: begin
        s_d.rd_ph = ~s_q.rd_ph;
        if (s_q.rd_ph) begin
          s_d.scan_i = s_q.scan_i + AW'(1);
          if (is_free && !s_q.free_ok) begin
            s_d.free_ok = 1'b1;
            s_d.free_i = s_q.scan_i;
          end
          if (is_hit || last) begin
            s_d.fst = F_IDLE;
            ram_wdata = {1'b1, {AGE_W{1'b0}}, s_q.src};
            if (is_hit) begin
              ram_we = 1'b1;
            end else if (s_q.free_ok || is_free) begin
              ram_we = 1'b1;
              ram_addr = s_q.free_ok ? s_q.free_i : s_q.scan_i;
              s_d.n_used = s_q.n_used + (AW + 1)'(1);
            end
          end
        end
      end
      F_AGE: begin
        s_d.rd_ph = ~s_q.rd_ph;
        if (s_q.rd_ph) begin
          s_d.scan_i = s_q.scan_i + AW'(1);
          if (last) s_d.fst = F_IDLE;
          if (ram_rdata[EW-1]) begin
            ram_we = 1'b1;
            if (age == AGE_LAST) begin
              ram_wdata = '0;
              s_d.n_used = s_q.n_used - (AW + 1)'(1);
            end else begin
              ram_wdata = {1'b1, age + AGE_W'(1), ram_rdata[47:0]};
            end
          end
        end
      end
      default: ;
    endcase

    if (!rst_s2_q) lan_rx_ready_out = 1'b0;
    // buffer saturation: lan data held off for SAT_MS
    if (lan_rx_valid_in && !lan_rx_ready_out) begin
      if (mtick && s_q.sat_ms != SAT_MS) s_d.sat_ms = s_q.sat_ms + 12'h1;
    end else begin
      s_d.sat_ms = 12'h0;
    end

    // status conditions by code
    ev[1] = 1'b0;
    ev[2] = (s_q.n_used == '0);
    ev[3] = !link_up && s_q.warm[1];
    ev[4] = (s_q.sat_ms == SAT_MS - 12'h1) && mtick;
    ev[5] = wan_rx_oversize_in;
    ev[6] = wan_rx_misalign_in;
    ev[7] = wan_rx_abort_in;
    ev[8] = wan_rx_crc_err_in;
    ev[9] = lan_rx_oversize_in;
    ev[10] = lan_rx_misalign_in;
    ev[11] = lan_rx_crc_err_in;
    for (int k = 2; k <= NUM_CODES; k++) begin
      if (s_q.latch[k] && s_q.shown[k] >= SHOW_TIMES) s_d.latch[k] = 1'b0;
    end
    if (s_q.lst == L_GAP && mtick && s_q.lms == GAP_MS - 12'h1 &&
        s_q.shown[s_q.code] != SHOW_TIMES) begin
      s_d.shown[s_q.code] = s_q.shown[s_q.code] + 4'h1;
    end
    for (int k = 2; k <= NUM_CODES; k++) begin
      if (ev[k]) begin
        s_d.latch[k] = 1'b1;
        s_d.shown[k] = 4'h0;
      end
    end
    act = s_d.latch;
    act[1] = 1'b1;

    // status lamp sequencer
    case (s_q.lst)
      L_PICK: begin
        s_d.code = CODE_OK;
        for (int k = 2; k <= NUM_CODES; k++) begin
          if (act[k]) s_d.code = 4'(k);
        end
        s_d.left = s_d.code;
        s_d.lms = 12'h0;
        s_d.lst = L_ON;
      end
      L_ON: begin
        if (mtick) begin
          s_d.lms = s_q.lms + 12'h1;
          if (s_q.lms == PULSE_ON_MS - 12'h1) begin
            s_d.lms = 12'h0;
            s_d.left = s_q.left - 4'h1;
            s_d.lst = (s_q.left == 4'h1) ? L_GAP : L_OFF;
          end
        end
      end
      L_OFF: begin
        if (mtick) begin
          s_d.lms = s_q.lms + 12'h1;
          if (s_q.lms == PULSE_OFF_MS - 12'h1) begin
            s_d.lms = 12'h0;
            s_d.lst = L_ON;
          end
        end
      end
      L_GAP: begin
        if (mtick) begin
          s_d.lms = s_q.lms + 12'h1;
          if (s_q.lms == GAP_MS - 12'h1) s_d.lst = L_PICK;
        end
      end
      default: s_d.lst = L_PICK;
    endcase
    s_d.sled = (s_d.lst == L_ON);
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '0;
    end else if (!rst_s2_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wan_txd_out    = s_q.txd;
  assign status_led_out = s_q.sled;
  assign link_led_out   = s_q.lled;
endmodule : lbl_bridge

// ---- verif/lbl_bridge_monitor.sv ----
/*
  lbl_bridge_monitor: port assertions for lbl_bridge, bound below.
  Assumes checked ports other than wan_clk_in and lan_link_ok_in belong to the core_clk_in domain.
*/
`timescale 1ns/1ns
module lbl_bridge_chk #(
  parameter int MS_CYCLES = 25000
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic lan_link_ok_in,
  input wire logic lan_rx_ready_out,
  input wire logic wan_clk_in,
  input wire logic wan_txd_out,
  input wire logic status_led_out,
  input wire logic link_led_out
);
  localparam int ON_C  = 250 * MS_CYCLES;
  localparam int GAP_C = 2000 * MS_CYCLES;
  logic [7:0]  ws_q;
  logic [31:0] on_q;
  logic [31:0] off_q;
  logic [3:0]  nb_q;
  logic        seen_q;
  logic        fell_w;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // a wan clock fall three to five core cycles back
  assign fell_w = |(ws_q[5:3] & ~ws_q[4:2]);
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ws_q   <= '0;
      on_q   <= '0;
      off_q  <= '0;
      nb_q   <= '0;
      seen_q <= 1'b0;
    end else begin
      ws_q  <= {ws_q[6:0], wan_clk_in};
      on_q  <= status_led_out ? on_q + 32'd1 : '0;
      off_q <= status_led_out ? '0 : off_q + 32'd1;
      if (!status_led_out && on_q != 0) seen_q <= 1'b1;
      if (status_led_out && off_q != 0) nb_q <= nb_q + 4'd1;
      else if (off_q > ON_C + 8) nb_q <= '0;
    end
  end
  sequence s_lamp_off;
    $fell(status_led_out);
  endsequence
  sequence s_lamp_on;
    $rose(status_led_out) && seen_q;
  endsequence
  sequence s_release;
    $rose(arst_n_in);
  endsequence
  a_pulse_len: assert property (s_lamp_off |->
    on_q inside {[ON_C-1:ON_C+2]}) else $error("lamp pulse length");
  a_dark_len: assert property (s_lamp_on |->
    off_q inside {[ON_C-1:ON_C+2], [GAP_C-1:GAP_C+2]})
    else $error("lamp dark length");
  a_burst_max: assert property (s_lamp_on |-> nb_q <= 4'd10)
    else $error("more than eleven pulses");
  a_link_steady: assert property (lan_link_ok_in[*8] |-> link_led_out)
    else $error("link lamp dark on good link");
  a_link_fall: assert property ($fell(lan_link_ok_in) |->
    ##[2:4] !link_led_out) else $error("link lamp late to go dark");
  a_txd_edge: assert property ($changed(wan_txd_out) |-> fell_w)
    else $error("txd moved without wan clock fall");
  a_ready_reset: assert property (s_release |->
    !lan_rx_ready_out[*2]) else $error("ready early after reset");
  a_quiet_start: assert property (s_release |->
    (!status_led_out && !wan_txd_out)[*2]) else $error("outputs early");
endmodule : lbl_bridge_chk

bind lbl_bridge lbl_bridge_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .core_clk_in      (core_clk_in),
  .arst_n_in        (arst_n_in),
  .lan_link_ok_in   (lan_link_ok_in),
  .lan_rx_ready_out (lan_rx_ready_out),
  .wan_clk_in       (wan_clk_in),
  .wan_txd_out      (wan_txd_out),
  .status_led_out   (status_led_out),
  .link_led_out     (link_led_out)
);

// ---- verif/lbl_drv_model.sv ----
/*
  lbl_drv_model: line driver serial port; makes the bit clock, cts
  and cd, and unframes txd. Assumes flags between frames.
*/
`timescale 1ns/1ns
module lbl_drv_model (
  input  wire logic   txd_in,
  input  wire logic   cts_en_in,
  output logic        wan_clk_out,
  output logic        cts_out,
  output logic        cd_out,
  output logic [7:0]  nfr_out,
  output logic [7:0]  len_out,
  output logic [15:0] res_out,
  output logic [7:0]  fr_out [0:31]
);
  logic [7:0]  sh = '0;
  logic [7:0]  by = '0;
  logic [15:0] c  = 16'hffff;
  int          nb = 0;
  int          ones = 0;
  int          n = 0;
  bit          sy = 1'b0;
  function automatic logic [15:0] crc(input logic [15:0] v,
                                      input logic [7:0]  b);
    for (int k = 0; k < 8; k++) begin
      v = (v[0] ^ b[k]) ? ((v >> 1) ^ 16'h8408) : (v >> 1);
    end
    return v;
  endfunction : crc
  initial begin
    wan_clk_out = 1'b0;
    nfr_out = '0;
    len_out = '0;
    res_out = '0;
  end
  // free-running clock of the clock-making end; bridge follows its rate
  always #160 wan_clk_out = ~wan_clk_out;
  // txd is never looped back toward the bridge
  assign cts_out = cts_en_in;
  assign cd_out  = cts_en_in;
  always @(posedge wan_clk_out) begin
    sh = {txd_in, sh[7:1]};
    if (sh == 8'h7e) begin
      if (sy && n > 2) begin
        nfr_out <= nfr_out + 8'h01;
        len_out <= 8'(n);
        res_out <= c;
      end
      sy = 1'b1;
      n = 0;
      nb = 0;
      ones = 0;
      c = 16'hffff;
    end else if (!txd_in && ones == 5) begin
      ones = 0;
    end else begin
      ones = txd_in ? ones + 1 : 0;
      if (ones == 7) sy = 1'b0;
      by = {txd_in, by[7:1]};
      nb++;
      if (nb == 8) begin
        if (n < 32) fr_out[n] <= by;
        c = crc(c, by);
        n++;
        nb = 0;
      end
    end
  end
endmodule : lbl_drv_model

// ---- verif/tb_top.sv ----
/*
  tb_top: bench for lbl_bridge with lamp codes, frame forwarding and
  link lamp. Assumes the line driver model and the bound checker.
*/
`timescale 1ns/1ns
module tb_top;
  import lbl_pkg::*;
  localparam int MSC = 2;
  localparam int DLY = 2;
  typedef struct {
    logic [47:0] d;
    logic [47:0] s;
    logic        c;
    logic        f;
  } lbl_row_t;
  // cts level, then whether the frame should reach the wan
  lbl_row_t rows [5] = '{
    '{48'hffffffffffff, 48'h0200000000a1, 1'b0, 1'b0},
    '{48'h0200000000a1, 48'h0200000000c3, 1'b1, 1'b0},
    '{48'hffffffffffff, 48'h0200000000b2, 1'b1, 1'b1},
    '{48'h01005e000001, 48'h0200000000c3, 1'b1, 1'b1},
    '{48'h0200000000d4, 48'h0200000000a1, 1'b1, 1'b1}};
  logic [7:0]  hdr [6] = '{8'hff, 8'h03, 8'h00, 8'h31, 8'h00, 8'h01};
  logic        clk = 1'b0, arst_n = 1'b0, lv = 1'b0, lsof = 1'b0;
  logic        leof = 1'b0, lcrc = 1'b0, wab = 1'b0, link_ok = 1'b1;
  logic        cts_en = 1'b1, lrdy, wclk, cts, cd, txd, sled, lled;
  logic [7:0]  ld = '0, nfr, flen;
  logic [15:0] res;
  logic [7:0]  fr [0:31];
  int          fails = 0, n_compared = 0, cyc = 0, n;
  lbl_bridge #(.MS_CYCLES(MSC)) dut_u (
    .core_clk_in(clk), .arst_n_in(arst_n), .lan_rx_data_in(ld),
    .lan_rx_valid_in(lv), .lan_rx_sof_in(lsof), .lan_rx_eof_in(leof),
    .lan_rx_ready_out(lrdy), .lan_rx_oversize_in(1'b0),
    .lan_rx_misalign_in(1'b0), .lan_rx_crc_err_in(lcrc),
    .lan_link_ok_in(link_ok), .wan_clk_in(wclk), .wan_cts_in(cts),
    .wan_cd_in(cd), .wan_txd_out(txd), .wan_rx_oversize_in(1'b0),
    .wan_rx_misalign_in(1'b0), .wan_rx_abort_in(wab),
    .wan_rx_crc_err_in(1'b0), .status_led_out(sled),
    .link_led_out(lled));
  lbl_drv_model drv_u (.txd_in(txd), .cts_en_in(cts_en),
    .wan_clk_out(wclk), .cts_out(cts), .cd_out(cd), .nfr_out(nfr),
    .len_out(flen), .res_out(res), .fr_out(fr));
  always #20 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      close_out();
    end
  end
  function automatic logic [7:0] fb(input lbl_row_t r, input int i);
    if (i < 6) return r.d[47-8*i -: 8];
    if (i < 12) return r.s[95-8*i -: 8];
    return 8'(i * 17);
  endfunction : fb
  task automatic put(input logic [7:0] b, input logic s, input logic e);
    logic r;
    ld = b;
    lsof = s;
    leof = e;
    lv = 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      r = lrdy;
      @(posedge clk);
    end
    #DLY;
  endtask : put
  // counts pulses of one burst, ends inside the dark gap
  task automatic burst(output int p);
    int k;
    k = 0;
    p = 0;
    while (!sled && k < 6000) begin
      @(posedge clk);
      #DLY;
      k++;
    end
    k = 1;
    while (k < 1500) begin
      if (sled) begin
        p += int'(k > 0);
        k = 0;
      end else k++;
      @(posedge clk);
      #DLY;
    end
  endtask : burst
  task automatic send_row(input lbl_row_t r);
    logic [7:0] n0;
    int         k;
    cts_en = r.c;
    repeat (8) @(posedge clk);
    #DLY;
    n0 = nfr;
    for (int i = 0; i < 16; i++) put(fb(r, i), i == 0, i == 15);
    lv = 1'b0;
    k = 0;
    while (nfr == n0 && k < 6000) begin
      @(posedge clk);
      #DLY;
      k++;
    end
    chk("frames", 32'(nfr - n0), 32'(r.f));
    if (r.f) begin
      chk("length", 32'(flen), 32'd24);
      chk("fcs", 32'(res), 32'h0000f0b8);
      for (int i = 0; i < 6; i++) begin
        chk("header", 32'(fr[i]), 32'(hdr[i]));
      end
      for (int i = 0; i < 16; i++) begin
        chk("byte", 32'(fr[i+6]), 32'(fb(r, i)));
      end
    end
  endtask : send_row
  initial begin
    repeat (2) @(posedge clk);
    #DLY;
    chk("reset outputs", 32'({lrdy, sled, lled, txd}), 32'h0);
    arst_n = 1'b1;
    burst(n);
    chk("empty table code", 32'(n), 32'd2);
    cts_en = 1'b0;
    burst(n);
    chk("cts code", 32'(n), 32'd3);
    cts_en = 1'b1;
    @(posedge clk);
    #DLY;
    lcrc = 1'b1;
    wab = 1'b1;
    @(posedge clk);
    #DLY;
    lcrc = 1'b0;
    wab = 1'b0;
    burst(n);
    chk("lan crc code", 32'(n), 32'd11);
    foreach (rows[i]) send_row(rows[i]);
    link_ok = 1'b0;
    repeat (5) @(posedge clk);
    #DLY;
    chk("link lamp off", 32'(lled), 32'h0);
    link_ok = 1'b1;
    repeat (5) @(posedge clk);
    #DLY;
    chk("link lamp on", 32'(lled), 32'h1);
    close_out();
  end
endmodule : tb_top
